/* File: uart_status_pkg.sv */
package uart_status_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_FCTL = 8'h08;
  localparam logic [7:0] ADDR_DIV = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_TXP = 8'h14;
  localparam logic [7:0] ADDR_RXP = 8'h18;
  localparam logic [7:0] ADDR_CNT = 8'h1C;
  // mode word bits
  localparam int MODE_PEN = 0;
  localparam int MODE_ODD = 1;
  localparam int MODE_STOP2 = 2;
  // control word bits
  localparam int CTRL_TX_ON = 5;
  localparam int CTRL_RX_ON = 4;
  // fifo control fields
  localparam int FCTL_TTRG_LO = 4;
  localparam int FCTL_RTRG_LO = 6;
  // status flag positions
  localparam int ST_RX_FAULT = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_TX_LOW = 5;
  localparam int ST_BREAK = 4;
  localparam int ST_FRAMING = 3;
  localparam int ST_PARITY = 2;
  localparam int ST_RX_FULL = 1;
  localparam int ST_RX_IDLE = 0;
  localparam logic [15:0] STAT_RESET = 16'h0060;
  localparam logic [7:0] CLEARABLE = 8'hF3;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] IDLE_ETU = 4'hF;
  localparam logic [7:0] DIV_RESET = 8'h00;

  typedef struct packed {
    logic pe;
    logic fe;
    logic [7:0] data;
  } rx_entry_s;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_e;

  function automatic logic [4:0] tx_trig(input logic [1:0] code);
    case (code)
      2'h0: tx_trig = 5'h08;
      2'h1: tx_trig = 5'h04;
      2'h2: tx_trig = 5'h02;
      default: tx_trig = 5'h01;
    endcase
  endfunction : tx_trig

  function automatic logic [4:0] rx_trig(input logic [1:0] code);
    case (code)
      2'h0: rx_trig = 5'h01;
      2'h1: rx_trig = 5'h04;
      2'h2: rx_trig = 5'h08;
      default: rx_trig = 5'h0E;
    endcase
  endfunction : rx_trig

  // parity over data plus the odd/even selector
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction : par_of
endpackage : uart_status_pkg

/* File: uart_status_flags.sv */
// Chosen here: the APB slave port and the placing of the registers.
module uart_status_flags (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic STBY_I,
  input wire logic MSTBY_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RXD_I,
  output logic TXD_O
);
  timeunit 1ns / 1ps;
  logic init;
  logic setup, access, wr, rd;
  logic [31:0] prdata_q;
  logic [2:0] mode_q;
  logic tx_on_q, rx_on_q;
  logic [3:0] trg_q;
  logic [7:0] div_q, os_cnt_q;
  logic os_tick;
  logic [2:0] rxs_q;
  logic rxd_q;
  // transmit side
  logic [7:0] tx_mem [16];
  logic [3:0] tx_wp_q, tx_rp_q;
  logic [4:0] tx_cnt_q, tx_trg;
  logic tx_push, tx_load, tx_done_ev, tx_off_ev;
  uart_status_pkg::tx_state_e tx_st_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_os_q;
  logic [2:0] tx_bit_q;
  logic tx_par_q, tx_stop2_q, txd_q;
  // receive side
  uart_status_pkg::rx_entry_s rx_mem [16];
  uart_status_pkg::rx_entry_s rx_head;
  logic [3:0] rx_wp_q, rx_rp_q;
  logic [4:0] rx_cnt_q, rx_trg, pe_cnt_q, fe_cnt_q;
  uart_status_pkg::rx_state_e rx_st_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_os_q;
  logic [2:0] rx_bit_q;
  logic rx_pbit_q, rx_done, rx_fe, rx_pe, rx_push, rx_pop;
  logic brk_ev, hold_q;
  logic idle_run_q, idle_ev;
  logic [3:0] idle_os_q, idle_etu_q;
  // status flags
  logic [7:0] flag_q, flag_d, seen_q, set_v, hclr_v, sclr_v;
  logic [15:0] stat_word;

  // standby holds everything at its reset value
  assign init = ~RSTN_I | STBY_I | MSTBY_I;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
  endfunction : mapped

  assign setup = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I;
  assign wr = access & PWRITE_I & mapped(PADDR_I);
  assign rd = access & ~PWRITE_I & mapped(PADDR_I);
  assign PREADY_O = access;
  assign PSLVERR_O = access & ~mapped(PADDR_I);
  assign PRDATA_O = prdata_q;
  assign TXD_O = txd_q;

  // three-stage line sync; change taken when stages 2 and 3 agree
  always_ff @(posedge MCLK_I) begin
    if (init) begin
      rxs_q <= 3'h7;
      rxd_q <= 1'b1;
    end else begin
      rxs_q <= {rxs_q[1:0], RXD_I};
      if (rxs_q[1] == rxs_q[2]) begin
        rxd_q <= rxs_q[2];
      end
    end
  end

  // config registers
  always_ff @(posedge MCLK_I) begin
    if (init) begin
      mode_q <= 3'h0;
      tx_on_q <= 1'b0;
      rx_on_q <= 1'b0;
      trg_q <= 4'h0;
      div_q <= uart_status_pkg::DIV_RESET;
    end else if (wr) begin
      case (PADDR_I)
        uart_status_pkg::ADDR_MODE: mode_q <= PWDATA_I[2:0];
        uart_status_pkg::ADDR_CTRL: begin
          tx_on_q <= PWDATA_I[uart_status_pkg::CTRL_TX_ON];
          rx_on_q <= PWDATA_I[uart_status_pkg::CTRL_RX_ON];
        end
        uart_status_pkg::ADDR_FCTL:
          trg_q <= PWDATA_I[uart_status_pkg::FCTL_TTRG_LO +: 4];
        uart_status_pkg::ADDR_DIV: div_q <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  assign tx_off_ev = wr && (PADDR_I == uart_status_pkg::ADDR_CTRL) &&
    tx_on_q && !PWDATA_I[uart_status_pkg::CTRL_TX_ON];
  assign tx_trg = uart_status_pkg::tx_trig(trg_q[1:0]);
  assign rx_trg = uart_status_pkg::rx_trig(trg_q[3:2]);

  // 16x oversample tick
  assign os_tick = (os_cnt_q == div_q);
  always_ff @(posedge MCLK_I) begin
    if (init || os_tick) begin
      os_cnt_q <= 8'h00;
    end else begin
      os_cnt_q <= os_cnt_q + 8'h01;
    end
  end

  // read data captured in setup so it is a flop in the access phase
  assign stat_word = {
    (pe_cnt_q[4] ? 4'hF : pe_cnt_q[3:0]),
    (fe_cnt_q[4] ? 4'hF : fe_cnt_q[3:0]),
    flag_q[7:4],
    (rx_cnt_q != 5'h00) & rx_head.fe,
    (rx_cnt_q != 5'h00) & rx_head.pe,
    flag_q[1:0]};
  always_ff @(posedge MCLK_I) begin
    if (init) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      case (PADDR_I)
        uart_status_pkg::ADDR_MODE: prdata_q <= {29'h0, mode_q};
        uart_status_pkg::ADDR_CTRL:
          prdata_q <= {26'h0, tx_on_q, rx_on_q, 4'h0};
        uart_status_pkg::ADDR_FCTL: prdata_q <= {24'h0, trg_q, 4'h0};
        uart_status_pkg::ADDR_DIV: prdata_q <= {24'h0, div_q};
        uart_status_pkg::ADDR_STAT: prdata_q <= {16'h0, stat_word};
        uart_status_pkg::ADDR_RXP:
          prdata_q <= {24'h0, rx_head.data};
        uart_status_pkg::ADDR_CNT:
          prdata_q <= {16'h0, 3'h0, tx_cnt_q, 3'h0, rx_cnt_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // transmit FIFO
  assign tx_push = wr && (PADDR_I == uart_status_pkg::ADDR_TXP) &&
    (tx_cnt_q != uart_status_pkg::FIFO_DEPTH);
  always_ff @(posedge MCLK_I) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= PWDATA_I[7:0];
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (init) begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      tx_cnt_q <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 4'h1;
      end
      if (tx_load) begin
        tx_rp_q <= tx_rp_q + 4'h1;
      end
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_load};
    end
  end

  // transmit shifter
  assign tx_load = tx_on_q && (tx_st_q == uart_status_pkg::TX_IDLE) &&
    (tx_cnt_q != 5'h00);
  assign tx_done_ev = (tx_st_q == uart_status_pkg::TX_STOP) && os_tick &&
    (tx_os_q == uart_status_pkg::OS_LAST) && !tx_stop2_q &&
    (tx_cnt_q == 5'h00);
  always_ff @(posedge MCLK_I) begin
    if (init || !tx_on_q) begin
      tx_st_q <= uart_status_pkg::TX_IDLE;
      txd_q <= 1'b1;
      tx_sh_q <= 8'h00;
      tx_os_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else begin
      if (os_tick && tx_st_q != uart_status_pkg::TX_IDLE) begin
        tx_os_q <= tx_os_q + 4'h1;
      end
      case (tx_st_q)
        uart_status_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_sh_q <= tx_mem[tx_rp_q];
            tx_par_q <= uart_status_pkg::par_of(tx_mem[tx_rp_q],
              mode_q[uart_status_pkg::MODE_ODD]);
            tx_stop2_q <= mode_q[uart_status_pkg::MODE_STOP2];
            tx_os_q <= 4'h0;
            txd_q <= 1'b0;
            tx_st_q <= uart_status_pkg::TX_START;
          end
        end
        uart_status_pkg::TX_START: begin
          if (os_tick && tx_os_q == uart_status_pkg::OS_LAST) begin
            txd_q <= tx_sh_q[0];
            tx_bit_q <= 3'h0;
            tx_st_q <= uart_status_pkg::TX_DATA;
          end
        end
        uart_status_pkg::TX_DATA: begin
          if (os_tick && tx_os_q == uart_status_pkg::OS_LAST) begin
            if (tx_bit_q == 3'h7) begin
              if (mode_q[uart_status_pkg::MODE_PEN]) begin
                txd_q <= tx_par_q;
                tx_st_q <= uart_status_pkg::TX_PAR;
              end else begin
                txd_q <= 1'b1;
                tx_st_q <= uart_status_pkg::TX_STOP;
              end
            end else begin
              txd_q <= tx_sh_q[1];
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        uart_status_pkg::TX_PAR: begin
          if (os_tick && tx_os_q == uart_status_pkg::OS_LAST) begin
            txd_q <= 1'b1;
            tx_st_q <= uart_status_pkg::TX_STOP;
          end
        end
        uart_status_pkg::TX_STOP: begin
          if (os_tick && tx_os_q == uart_status_pkg::OS_LAST) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_st_q <= uart_status_pkg::TX_IDLE;
            end
          end
        end
        default: tx_st_q <= uart_status_pkg::TX_IDLE;
      endcase
    end
  end

  // receive engine; disabling it touches no flag
  assign rx_done = (rx_st_q == uart_status_pkg::RX_STOP) && os_tick &&
    (rx_os_q == uart_status_pkg::OS_LAST);
  assign rx_fe = ~rxd_q;
  assign rx_pe = mode_q[uart_status_pkg::MODE_PEN] &
    (uart_status_pkg::par_of(rx_sh_q, mode_q[uart_status_pkg::MODE_ODD])
    ^ rx_pbit_q);
  always_ff @(posedge MCLK_I) begin
    if (init || !rx_on_q) begin
      rx_st_q <= uart_status_pkg::RX_IDLE;
      rx_sh_q <= 8'h00;
      rx_os_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_pbit_q <= 1'b0;
    end else begin
      if (os_tick && rx_st_q != uart_status_pkg::RX_IDLE) begin
        rx_os_q <= rx_os_q + 4'h1;
      end
      case (rx_st_q)
        uart_status_pkg::RX_IDLE: begin
          if (!rxd_q && !hold_q) begin
            rx_os_q <= 4'h0;
            rx_st_q <= uart_status_pkg::RX_START;
          end
        end
        uart_status_pkg::RX_START: begin
          if (os_tick && rx_os_q == uart_status_pkg::OS_MID) begin
            rx_os_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_st_q <= rxd_q ? uart_status_pkg::RX_IDLE :
              uart_status_pkg::RX_DATA;
          end
        end
        uart_status_pkg::RX_DATA: begin
          if (os_tick && rx_os_q == uart_status_pkg::OS_LAST) begin
            rx_sh_q <= {rxd_q, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= mode_q[uart_status_pkg::MODE_PEN] ?
                uart_status_pkg::RX_PAR : uart_status_pkg::RX_STOP;
            end
          end
        end
        uart_status_pkg::RX_PAR: begin
          if (os_tick && rx_os_q == uart_status_pkg::OS_LAST) begin
            rx_pbit_q <= rxd_q;
            rx_st_q <= uart_status_pkg::RX_STOP;
          end
        end
        uart_status_pkg::RX_STOP: begin
          // a second stop bit is never looked at
          if (rx_done) begin
            rx_st_q <= uart_status_pkg::RX_IDLE;
          end
        end
        default: rx_st_q <= uart_status_pkg::RX_IDLE;
      endcase
    end
  end

  // break: framing fault on an all-space frame; mute until mark
  assign brk_ev = rx_done && rx_fe && (rx_sh_q == 8'h00) &&
    !(mode_q[uart_status_pkg::MODE_PEN] && rx_pbit_q);
  always_ff @(posedge MCLK_I) begin
    if (init || rxd_q) begin
      hold_q <= 1'b0;
    end else if (brk_ev) begin
      hold_q <= 1'b1;
    end
  end

  // receive FIFO; faulty characters are stored too
  assign rx_push = rx_done && !hold_q &&
    (rx_cnt_q != uart_status_pkg::FIFO_DEPTH);
  assign rx_pop = rd && (PADDR_I == uart_status_pkg::ADDR_RXP) &&
    (rx_cnt_q != 5'h00);
  assign rx_head = rx_mem[rx_rp_q];
  always_ff @(posedge MCLK_I) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= '{pe: rx_pe, fe: rx_fe, data: rx_sh_q};
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (init) begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      rx_cnt_q <= 5'h00;
      pe_cnt_q <= 5'h00;
      fe_cnt_q <= 5'h00;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 4'h1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 4'h1;
      end
      rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
      pe_cnt_q <= pe_cnt_q + {4'h0, rx_push & rx_pe} -
        {4'h0, rx_pop & rx_head.pe};
      fe_cnt_q <= fe_cnt_q + {4'h0, rx_push & rx_fe} -
        {4'h0, rx_pop & rx_head.fe};
    end
  end

  // idle timer counts bit times after the last stop bit
  assign idle_ev = idle_run_q && os_tick &&
    (idle_os_q == uart_status_pkg::OS_LAST) &&
    (idle_etu_q == uart_status_pkg::IDLE_ETU - 4'h1);
  always_ff @(posedge MCLK_I) begin
    if (init || rx_st_q == uart_status_pkg::RX_START) begin
      idle_run_q <= 1'b0;
      idle_os_q <= 4'h0;
      idle_etu_q <= 4'h0;
    end else if (rx_done) begin
      idle_run_q <= 1'b1;
      idle_os_q <= 4'h0;
      idle_etu_q <= 4'h0;
    end else if (idle_run_q && os_tick) begin
      idle_os_q <= idle_os_q + 4'h1;
      if (idle_os_q == uart_status_pkg::OS_LAST) begin
        idle_etu_q <= idle_etu_q + 4'h1;
        if (idle_ev) begin
          idle_run_q <= 1'b0;
        end
      end
    end
  end

  // hardware set terms win over any clear in the same cycle
  always_comb begin
    set_v = 8'h00;
    hclr_v = 8'h00;
    sclr_v = 8'h00;
    set_v[uart_status_pkg::ST_RX_FAULT] = rx_done & (rx_fe | rx_pe);
    set_v[uart_status_pkg::ST_TX_DONE] = tx_done_ev | tx_off_ev;
    set_v[uart_status_pkg::ST_TX_LOW] = tx_load &
      ((tx_cnt_q - 5'h01) < tx_trg);
    set_v[uart_status_pkg::ST_BREAK] = brk_ev;
    set_v[uart_status_pkg::ST_RX_FULL] = rx_cnt_q > rx_trg;
    set_v[uart_status_pkg::ST_RX_IDLE] = idle_ev &&
      (rx_cnt_q != 5'h00) && (rx_cnt_q < rx_trg);
    hclr_v[uart_status_pkg::ST_TX_DONE] = tx_push;
    hclr_v[uart_status_pkg::ST_TX_LOW] = tx_push &
      ((tx_cnt_q + 5'h01) > tx_trg);
    if (wr && PADDR_I == uart_status_pkg::ADDR_STAT) begin
      // zero only clears what was seen as one; ones do nothing
      sclr_v = ~PWDATA_I[7:0] & seen_q &
        uart_status_pkg::CLEARABLE;
      if (rx_cnt_q >= rx_trg) begin
        sclr_v[uart_status_pkg::ST_RX_FULL] = 1'b0;
      end
    end
    flag_d = (flag_q & ~(hclr_v | sclr_v)) | set_v;
  end

  always_ff @(posedge MCLK_I) begin
    if (init) begin
      flag_q <= uart_status_pkg::STAT_RESET[7:0];
    end else begin
      flag_q <= flag_d & uart_status_pkg::CLEARABLE;
    end
  end

  // seen record: armed by a status read, dropped on each new set
  always_ff @(posedge MCLK_I) begin
    if (init) begin
      seen_q <= 8'h00;
    end else if (rd && PADDR_I == uart_status_pkg::ADDR_STAT) begin
      seen_q <= (seen_q | prdata_q[7:0]) & flag_d & ~set_v;
    end else begin
      seen_q <= seen_q & flag_d & ~set_v;
    end
  end
endmodule : uart_status_flags

/* File: uart_peer.sv */
module uart_peer (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  // divisor is 0 whenever a frame is sent or heard, so a bit is 16 clocks
  initial rxd_o = 1'b1;
  task automatic bit_out(input logic v);
    rxd_o <= v;
    repeat (16) @(posedge clk_i);
  endtask : bit_out
  // f: [0] bad stop [1] parity [2] odd [3] wrong parity [4] two stops
  task automatic send(input logic [7:0] d, input logic [4:0] f);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (f[1]) bit_out(^d ^ f[2] ^ f[3]);
    bit_out(~f[0]);
    if (f[4]) bit_out(1'b1);
    // line returns to mark, so a break ends with the frame
    repeat (2) bit_out(1'b1);
  endtask : send
  // listener for the transmit line, 8 data bits, no parity
  always begin
    @(negedge txd_i);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk_i);
      sh[i] = txd_i;
    end
    repeat (16) @(posedge clk_i);
    got_q.push_back(sh);
  end
endmodule : uart_peer

/* File: uart_status_sva.sv */
module uart_status_sva (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic STBY_I,
  input wire logic MSTBY_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic RXD_I,
  input wire logic TXD_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic access;
  logic unmapped;
  logic stat_setup;
  logic hold;
  logic tx_on_q;
  logic [7:0] div_q;
  assign access = PSEL_I && PENABLE_I;
  assign unmapped = (PADDR_I > 8'h1C) || (PADDR_I[1:0] != 2'h0);
  assign stat_setup = PSEL_I && !PENABLE_I && !PWRITE_I
    && PADDR_I == uart_status_pkg::ADDR_STAT;
  assign hold = !(PSEL_I && !PENABLE_I) && !STBY_I && !MSTBY_I;
  // shadow of the enable bit, rebuilt from bus writes
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || STBY_I || MSTBY_I) tx_on_q <= 1'b0;
    else if (access && PWRITE_I && PADDR_I == uart_status_pkg::ADDR_CTRL)
      tx_on_q <= PWDATA_I[uart_status_pkg::CTRL_TX_ON];
  end
  // bit-time check only holds for divisor 0
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || STBY_I || MSTBY_I) div_q <= 8'h00;
    else if (access && PWRITE_I && PADDR_I == uart_status_pkg::ADDR_DIV)
      div_q <= PWDATA_I[7:0];
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);
  a_pready_zero_wait: assert property (
    PREADY_O == access) else $error("pready not tied to access phase");
  a_slverr_decode: assert property (
    access |-> PSLVERR_O == unmapped) else $error("slverr decode wrong");
  a_unmapped_read_zero: assert property (
    access && !PWRITE_I && unmapped |-> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_upper_half_zero: assert property (
    access && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_read_data_holds: assert property (
    hold |=> $stable(PRDATA_O)) else $error("read data moved");
  a_status_reset_value: assert property (
    (!$past(RSTN_I) || $past(STBY_I) || $past(MSTBY_I)) && stat_setup
    |=> PRDATA_O[15:0] == uart_status_pkg::STAT_RESET)
    else $error("status not at reset value");
  a_reset_line_idle: assert property (
    $rose(RSTN_I) |-> TXD_O && PRDATA_O == 32'h0)
    else $error("outputs not idle after reset");
  a_standby_line_idle: assert property (
    STBY_I || MSTBY_I |=> TXD_O) else $error("line not idle in standby");
  a_tx_needs_on: assert property (
    $fell(TXD_O) |-> tx_on_q) else $error("transmit while disabled");
  a_bit_time_hold: assert property (
    disable iff (!RSTN_I || STBY_I || MSTBY_I)
    $fell(TXD_O) && div_q == 8'h00 |-> !TXD_O [*8] ##1 !TXD_O [*8])
    else $error("low bit shorter than 16 clocks");
endmodule : uart_status_sva

bind uart_status_flags uart_status_sva sva_i (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .STBY_I(STBY_I),
  .MSTBY_I(MSTBY_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .RXD_I(RXD_I), .TXD_O(TXD_O));

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK_I, RSTN_I, STBY_I, MSTBY_I, PSEL_I, PENABLE_I, PWRITE_I;
  logic [7:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, s;
  logic PREADY_O, PSLVERR_O, RXD_I, TXD_O;
  logic slv;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] d, e;
  logic [4:0] f;
  logic [7:0] sent_q[$];
  logic [4:0] cases[8] = '{5'h00, 5'h01, 5'h02, 5'h0A, 5'h06, 5'h0E,
    5'h10, 5'h11};

  uart_status_flags dut (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
    .STBY_I(STBY_I), .MSTBY_I(MSTBY_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .RXD_I(RXD_I), .TXD_O(TXD_O));
  uart_peer peer (.clk_i(MCLK_I), .txd_i(TXD_O), .rxd_o(RXD_I));

  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end

  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // one transfer; idle cycle after it keeps drives one per step
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= wd;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge MCLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    s = PRDATA_O;
    slv = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge MCLK_I);
  endtask : apb

  task automatic wait_flag(input int b);
    for (int n = 0; n < 1500; n++) begin
      apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
      if (s[b] === 1'b1) break;
    end
  endtask : wait_flag

  task automatic stby(input logic m);
    if (m) MSTBY_I <= 1'b1;
    else STBY_I <= 1'b1;
    repeat (2) @(posedge MCLK_I);
    STBY_I <= 1'b0;
    MSTBY_I <= 1'b0;
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("stat_standby", s, 32'h00000060);
  endtask : stby

  function automatic logic [7:0] exp_rx(input logic [4:0] fl,
      input logic [7:0] dd);
    logic pe;
    pe = fl[1] & fl[3];
    exp_rx = {fl[0] | pe, 2'b00, fl[0] && dd == 8'h00, fl[0], pe, 2'b00};
  endfunction : exp_rx

  initial begin
    repeat (40000) @(posedge MCLK_I);
    miscompares++;
    finish_test();
  end

  initial begin
    RSTN_I = 1'b0;
    STBY_I = 1'b0;
    MSTBY_I = 1'b0;
    PSEL_I = 1'b0;
    PENABLE_I = 1'b0;
    PWRITE_I = 1'b0;
    PADDR_I = 8'h00;
    PWDATA_I = 32'h0;
    void'($urandom(56124));
    repeat (4) @(posedge MCLK_I);
    RSTN_I <= 1'b1;
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("stat_reset", s, 32'h00000060);
    apb(1'b1, uart_status_pkg::ADDR_STAT, 32'hFFFF);
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("stat_ones", s, 32'h00000060);
    apb(1'b1, uart_status_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("stat_clear", s, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped_rd", s, 32'h0);
    check("unmapped_err", slv, 1'b1);
    apb(1'b1, 8'h11, 32'h1);
    check("unmapped_wr_err", slv, 1'b1);
    apb(1'b1, uart_status_pkg::ADDR_DIV, 32'h0000_00A5);
    apb(1'b0, uart_status_pkg::ADDR_DIV, 32'h0);
    check("div_rw", s, 32'h0000_00A5);
    check("mapped_err", slv, 1'b0);
    // fill with the transmitter off, then let it drain
    stby(1'b0);
    apb(1'b0, uart_status_pkg::ADDR_DIV, 32'h0);
    check("div_standby", s, 32'h0);
    repeat (18) begin
      d = 8'($urandom);
      sent_q.push_back(d);
      apb(1'b1, uart_status_pkg::ADDR_TXP, {24'h0, d});
    end
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("tx_flags", s[6:5], 2'b00);
    apb(1'b1, uart_status_pkg::ADDR_CNT, 32'hFFFF_FFFF);
    apb(1'b0, uart_status_pkg::ADDR_CNT, 32'h0);
    check("tx_count", s, 32'h00001000);
    apb(1'b1, uart_status_pkg::ADDR_CTRL, 32'h20);
    wait_flag(6);
    check("tx_end", s[6:5], 2'b11);
    check("tx_sent", peer.got_q.size(), 16);
    foreach (peer.got_q[i]) check("tx_byte", peer.got_q[i], sent_q[i]);
    apb(1'b1, uart_status_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("tx_cleared", s[6:5], 2'b00);
    apb(1'b1, uart_status_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("tx_off_end", s[6], 1'b1);
    stby(1'b1);
    apb(1'b1, uart_status_pkg::ADDR_CTRL, 32'h10);
    foreach (cases[i]) begin
      f = cases[i];
      d = 8'($urandom) | 8'h10;
      e = exp_rx(f, d);
      apb(1'b1, uart_status_pkg::ADDR_MODE, {29'h0, f[4], f[2], f[1]});
      peer.send(d, f);
      apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
      check("rx_flags", s[7:0] & 8'h9F, e);
      check("err_counts", s[15:8], {3'h0, e[2], 3'h0, e[3]});
      apb(1'b1, uart_status_pkg::ADDR_CTRL, 32'h0);
      apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
      check("fault_kept", s[7], e[7]);
      apb(1'b1, uart_status_pkg::ADDR_STAT, 32'h0);
      apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
      check("fault_clear", s[7:2] & 6'h23, {4'h0, e[3:2]});
      apb(1'b0, uart_status_pkg::ADDR_RXP, 32'h0);
      check("rx_data", s[7:0], d);
      apb(1'b1, uart_status_pkg::ADDR_CTRL, 32'h10);
    end
    peer.send(8'h00, 5'h01);
    apb(1'b1, uart_status_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("brk_unread", s[4], 1'b1);
    apb(1'b1, uart_status_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("brk_clear", s[4], 1'b0);
    apb(1'b0, uart_status_pkg::ADDR_RXP, 32'h0);
    check("brk_data", s[7:0], 8'h00);
    apb(1'b1, uart_status_pkg::ADDR_FCTL, 32'h40);
    sent_q.delete();
    repeat (5) begin
      d = 8'($urandom);
      sent_q.push_back(d);
      peer.send(d, 5'h10);
    end
    apb(1'b0, uart_status_pkg::ADDR_STAT, 32'h0);
    check("rx_full", s[1:0], 2'b10);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, uart_status_pkg::ADDR_RXP, 32'h0);
      check("rx_order", s[7:0], sent_q[i]);
    end
    wait_flag(0);
    check("rx_idle", s[0], 1'b1);
    finish_test();
  end
endmodule : tb
